//--- rtl/mfio_pkg.sv
// ****************************************************************
// multifunction io / totalizer shared definitions
// ****************************************************************
package mfio_pkg;

   // ****************************************************************
   // register bus geometry
   // ****************************************************************
   localparam int ADDR_W = 8;   // byte address width
   localparam int DATA_W = 32;  // register data width

   // ****************************************************************
   // register offsets (byte addresses, one word each)
   // ****************************************************************
   localparam logic [7:0] OFS_PORT0 = 8'h00;   // port 0 input read / output latch
   localparam logic [7:0] OFS_PORT1 = 8'h04;   // port 1 input read / output latch
   localparam logic [7:0] OFS_PORT16 = 8'h08;  // both ports as one word
   localparam logic [7:0] OFS_CTRL = 8'h0c;    // configuration bits
   localparam logic [7:0] OFS_COUNT = 8'h10;   // totalizer count, write clears
   localparam logic [7:0] OFS_DAC0 = 8'h14;    // analog output code, channel 04
   localparam logic [7:0] OFS_DAC1 = 8'h18;    // analog output code, channel 05
   localparam logic [7:0] OFS_SENSE0 = 8'h1c;  // sense reading, channel 06
   localparam logic [7:0] OFS_SENSE1 = 8'h20;  // sense reading, channel 07
   localparam logic [7:0] OFS_STATUS = 8'h24;  // sticky status, write one to clear

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CTRL_EDGE_FALL = 0;  // 1: count falling edges
   localparam int CTRL_THR_AC = 1;     // 1: zero-crossing threshold, 0: ttl
   localparam int CTRL_SCAN_P0 = 2;    // port 0 in scan list
   localparam int CTRL_SCAN_P1 = 3;    // port 1 in scan list
   localparam int CTRL_SCAN_CNT = 4;   // totalizer in scan list
   localparam int CTRL_DAC0_CUR = 5;   // channel 04 current mode
   localparam int CTRL_DAC1_CUR = 6;   // channel 05 current mode
   localparam int CTRL_W = 7;
   localparam int STAT_REFUSED = 0;    // combined read refused
   localparam int STAT_SCAN_BUSY = 1;  // scan sequence in progress

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [6:0] CTRL_RST = 7'h00;     // ttl threshold, rising edges
   localparam logic [7:0] PORT_OUT_RST = 8'hff; // open drain released
   localparam logic [17:0] DAC_RST = 18'h00000; // mid-scale code zero

   // ****************************************************************
   // widths and channel numbers
   // ****************************************************************
   localparam int PORT_W = 8;
   localparam int CNT_W = 26;
   localparam int DAC_W = 18;
   localparam logic [7:0] CH_PORT0 = 8'h01;
   localparam logic [7:0] CH_PORT1 = 8'h02;
   localparam logic [7:0] CH_COUNT = 8'h03;
   localparam logic [7:0] CH_DAC0 = 8'h04;
   localparam logic [7:0] CH_DAC1 = 8'h05;
   localparam logic [7:0] CH_SENSE0 = 8'h06;
   localparam logic [7:0] CH_SENSE1 = 8'h07;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 20;     // 50 MHz core clock
   localparam int PULSE_RATE_KHZ = 100;   // highest counted pulse rate
   localparam int PULSE_HALF_NS = 1000000 / (2 * PULSE_RATE_KHZ);
   localparam int PULSE_HALF_CYC = PULSE_HALF_NS / CLK_PERIOD_NS;  // round down
   localparam int SYNC_STAGES = 2;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic we;
      logic re;
      logic remote;  // 1: remote interface, 0: front panel
   } mfio_bus_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] chan;
      logic [CNT_W-1:0] data;
   } mfio_reading_t;

   typedef enum logic [1:0] {
      SC_IDLE = 2'b00,
      SC_PORT0 = 2'b01,
      SC_PORT1 = 2'b10,
      SC_COUNT = 2'b11
   } mfio_scan_t;

endpackage : mfio_pkg

//--- rtl/mfio_top.sv
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
// Summary of operation
// - two independent eight-bit ttl digital ports
// - front panel reads one port only
// - remote word read only when unscanned
// - scan delivers port values and count
// - totalizer count is twenty-six bits wide
// - every pulse counted up to 100 kHz
// - configurable rising or falling edge counting
// - high gate enables counting when high
// - low gate enables counting when low
// - count only when both gates enable
// - zero-crossing or ttl threshold, ttl default
// - outputs channels 04, 05, senses 06, 07
// - eighteen-bit code per analog output
// - current or voltage mode per output
module mfio_top #(
   parameter int PORT_W = 8,
   parameter int CNT_W = 26,
   parameter int DAC_W = 18
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // register port
   input wire mfio_pkg::mfio_bus_req_t bus_req_i,
   output logic [mfio_pkg::DATA_W-1:0] bus_rdata_o,
   // digital port pins, open drain
   input wire logic [2*PORT_W-1:0] pio_in_i,
   output logic [2*PORT_W-1:0] pio_out_o,
   output logic [2*PORT_W-1:0] pio_oe_o,
   // totalizer pins
   input wire logic cnt_ttl_i,
   input wire logic cnt_ac_i,
   input wire logic gate_hi_i,
   input wire logic gate_lo_n_i,
   // analog output and sense
   output logic [2*DAC_W-1:0] dac_code_o,
   output logic [1:0] dac_cur_mode_o,
   input wire logic [2*DAC_W-1:0] sense_code_i,
   // scan sequencing
   input wire logic scan_start_i,
   output mfio_pkg::mfio_reading_t scan_rd_o
);
   import mfio_pkg::*;

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   generate
      if (PORT_W != 8 || CNT_W < 1 || CNT_W > DATA_W || DAC_W < 1 || DAC_W > DATA_W) begin : g_bad
         $error("mfio_top: parameters cannot be served");
      end
   endgenerate

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [DATA_W-1:0] rdata;       // read data, one cycle after strobe
      logic [2*PORT_W-1:0] out_latch; // open-drain output latches
      logic [CTRL_W-1:0] ctrl;        // configuration bits
      logic [2*DAC_W-1:0] dac;        // two output codes
      logic refused;                  // sticky combined-read refusal
      mfio_scan_t scan;               // scan sequencer state
      mfio_reading_t rd;              // scan reading out
   } mfio_st_t;

   mfio_st_t st_r;
   mfio_st_t st_nxt;
   logic [CNT_W-1:0] count;      // totalizer count
   logic cnt_sel;                // pulse source after threshold select
   logic cnt_clr;                // software clear of count
   logic p0_scan;                // port 0 in scan list
   logic p1_scan;                // port 1 in scan list
   logic wr;                     // write strobe qualified
   logic rd;                     // read strobe qualified
   logic [PORT_W-1:0] port_in [2]; // input ports split
   mfio_scan_t scan_next;        // next scan list member

   // ****************************************************************
   // port split, one generate per port
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_port
         assign port_in[gi] = pio_in_i[gi*PORT_W +: PORT_W];
         // open drain: a zero in the latch pulls the line low
         assign pio_out_o[gi*PORT_W +: PORT_W] = '0;
         assign pio_oe_o[gi*PORT_W +: PORT_W] = ~st_r.out_latch[gi*PORT_W +: PORT_W];
      end
   endgenerate

   // ****************************************************************
   // threshold select ahead of the synchroniser
   // ****************************************************************
   // the threshold control bit only chooses which comparator feeds the counter
   assign cnt_sel = st_r.ctrl[CTRL_THR_AC] ? cnt_ac_i : cnt_ttl_i;

   assign wr = bus_req_i.we;
   assign rd = bus_req_i.re;
   assign cnt_clr = wr && bus_req_i.addr == OFS_COUNT;
   assign p0_scan = st_r.ctrl[CTRL_SCAN_P0];
   assign p1_scan = st_r.ctrl[CTRL_SCAN_P1];

   // ****************************************************************
   // totalizer
   // ****************************************************************
   mfio_totalizer #(
      .CNT_W(CNT_W),
      .HALF_CYC(PULSE_HALF_CYC)
   ) u_tot (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .cnt_in_i(cnt_sel),
      .gate_hi_i(gate_hi_i),
      .gate_lo_n_i(gate_lo_n_i),
      .edge_fall_i(st_r.ctrl[CTRL_EDGE_FALL]),
      .clr_i(cnt_clr),
      .count_o(count)
   );

   // ****************************************************************
   // next scan member after the current state
   // ****************************************************************
   always_comb begin
      scan_next = SC_IDLE;
      case (st_r.scan)
         SC_IDLE: begin
            if (p0_scan) begin
               scan_next = SC_PORT0;
            end else if (p1_scan) begin
               scan_next = SC_PORT1;
            end else if (st_r.ctrl[CTRL_SCAN_CNT]) begin
               scan_next = SC_COUNT;
            end
         end
         SC_PORT0: begin
            if (p1_scan) begin
               scan_next = SC_PORT1;
            end else if (st_r.ctrl[CTRL_SCAN_CNT]) begin
               scan_next = SC_COUNT;
            end
         end
         SC_PORT1: begin
            if (st_r.ctrl[CTRL_SCAN_CNT]) begin
               scan_next = SC_COUNT;
            end
         end
         default: begin
            scan_next = SC_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // register access and scan sequencing
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = '0;
      st_nxt.rd = '0;
      // writes
      if (wr) begin
         case (bus_req_i.addr)
            OFS_PORT0: st_nxt.out_latch[PORT_W-1:0] = bus_req_i.wdata[PORT_W-1:0];
            OFS_PORT1: st_nxt.out_latch[2*PORT_W-1:PORT_W] = bus_req_i.wdata[PORT_W-1:0];
            OFS_CTRL: st_nxt.ctrl = bus_req_i.wdata[CTRL_W-1:0];
            OFS_DAC0: st_nxt.dac[DAC_W-1:0] = bus_req_i.wdata[DAC_W-1:0];
            OFS_DAC1: st_nxt.dac[2*DAC_W-1:DAC_W] = bus_req_i.wdata[DAC_W-1:0];
            OFS_STATUS: begin
               // write one clears
               if (bus_req_i.wdata[STAT_REFUSED]) begin
                  st_nxt.refused = 1'b0;
               end
            end
            default: begin
               // unmapped or read-only: ignored
            end
         endcase
      end
      // reads, data stands in the next cycle
      if (rd) begin
         case (bus_req_i.addr)
            // a single port read returns eight bits only
            OFS_PORT0: st_nxt.rdata = DATA_W'(port_in[0]);
            OFS_PORT1: st_nxt.rdata = DATA_W'(port_in[1]);
            OFS_PORT16: begin
               if (bus_req_i.remote && !p0_scan && !p1_scan) begin
                  st_nxt.rdata = DATA_W'({port_in[1], port_in[0]});
               end else begin
                  // front panel or scanned port: answer zero, flag it
                  st_nxt.refused = 1'b1;
               end
            end
            OFS_CTRL: st_nxt.rdata = DATA_W'(st_r.ctrl);
            OFS_COUNT: st_nxt.rdata = DATA_W'(count);
            OFS_DAC0: st_nxt.rdata = DATA_W'(st_r.dac[DAC_W-1:0]);
            OFS_DAC1: st_nxt.rdata = DATA_W'(st_r.dac[2*DAC_W-1:DAC_W]);
            OFS_SENSE0: st_nxt.rdata = DATA_W'(sense_code_i[DAC_W-1:0]);
            OFS_SENSE1: st_nxt.rdata = DATA_W'(sense_code_i[2*DAC_W-1:DAC_W]);
            OFS_STATUS: st_nxt.rdata = DATA_W'({st_r.scan != SC_IDLE, st_r.refused});
            default: st_nxt.rdata = '0;
         endcase
      end
      // scan: one reading per cycle for each list member
      case (st_r.scan)
         SC_IDLE: begin
            if (scan_start_i) begin
               st_nxt.scan = scan_next;
            end
         end
         SC_PORT0: begin
            st_nxt.rd = '{valid: 1'b1, chan: CH_PORT0, data: CNT_W'(port_in[0])};
            st_nxt.scan = scan_next;
         end
         SC_PORT1: begin
            st_nxt.rd = '{valid: 1'b1, chan: CH_PORT1, data: CNT_W'(port_in[1])};
            st_nxt.scan = scan_next;
         end
         SC_COUNT: begin
            st_nxt.rd = '{valid: 1'b1, chan: CH_COUNT, data: count};
            st_nxt.scan = SC_IDLE;
         end
         default: begin
            st_nxt.scan = SC_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_r.rdata <= '0;
         st_r.out_latch <= {2{PORT_OUT_RST}};
         st_r.ctrl <= CTRL_RST;
         st_r.dac <= {2{DAC_RST}};
         st_r.refused <= 1'b0;
         st_r.scan <= SC_IDLE;
         st_r.rd <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign bus_rdata_o = st_r.rdata;
   assign dac_code_o = st_r.dac;
   // mode bit tells the front end how to scale the code
   assign dac_cur_mode_o = {st_r.ctrl[CTRL_DAC1_CUR], st_r.ctrl[CTRL_DAC0_CUR]};
   assign scan_rd_o = st_r.rd;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_front_word_read;
      rd && bus_req_i.addr == OFS_PORT16 && !bus_req_i.remote;
   endsequence

   sequence s_scan_all;
      (st_r.scan == SC_IDLE && scan_start_i && st_r.ctrl[4:2] == 3'b111) ##1 st_r.scan == SC_PORT0;
   endsequence

   a_front_one_port: assert property (s_front_word_read |=> bus_rdata_o == '0 && st_r.refused)
      else $error("front panel word read not refused");
   a_port_read_byte: assert property ((rd && bus_req_i.addr == OFS_PORT1)
      |=> bus_rdata_o == DATA_W'($past(pio_in_i[2*PORT_W-1:PORT_W])))
      else $error("single port read wrong");
   a_remote_word: assert property ((rd && bus_req_i.addr == OFS_PORT16 && bus_req_i.remote && !p0_scan && !p1_scan)
      |=> bus_rdata_o == DATA_W'($past(pio_in_i)))
      else $error("remote word read wrong");
   a_scan_word_block: assert property ((rd && bus_req_i.addr == OFS_PORT16 && (p0_scan || p1_scan))
      |=> bus_rdata_o == '0)
      else $error("word read allowed with scanned port");
   a_scan_order: assert property (s_scan_all |=> scan_rd_o.valid && scan_rd_o.chan == CH_PORT0
      ##1 scan_rd_o.chan == CH_PORT1 ##1 scan_rd_o.chan == CH_COUNT ##1 !scan_rd_o.valid)
      else $error("scan readings out of order");
   a_dac_code_load: assert property ((wr && bus_req_i.addr == OFS_DAC1)
      |=> dac_code_o[2*DAC_W-1:DAC_W] == $past(bus_req_i.wdata[DAC_W-1:0]))
      else $error("output code not loaded");
   a_dac_mode_set: assert property ((wr && bus_req_i.addr == OFS_CTRL)
      |=> dac_cur_mode_o == $past(bus_req_i.wdata[CTRL_DAC1_CUR:CTRL_DAC0_CUR]))
      else $error("output mode not taken");
   a_open_drain: assert property ((wr && bus_req_i.addr == OFS_PORT0)
      |=> pio_oe_o[PORT_W-1:0] == ~$past(bus_req_i.wdata[PORT_W-1:0]))
      else $error("port output enable wrong");

endmodule : mfio_top

//--- rtl/mfio_totalizer.sv
`timescale 1ns/100ps
// ****************************************************************
// gated edge totalizer
// ****************************************************************
module mfio_totalizer #(
   parameter int CNT_W = 26,
   parameter int HALF_CYC = 250
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // pulse and gate pins
   input wire logic cnt_in_i,
   input wire logic gate_hi_i,
   input wire logic gate_lo_n_i,
   // control
   input wire logic edge_fall_i,
   input wire logic clr_i,
   // count
   output logic [CNT_W-1:0] count_o
);
   import mfio_pkg::*;

   // refuse a clock too slow to see every pulse half
   generate
      if (CNT_W < 1 || HALF_CYC < SYNC_STAGES + 1) begin : g_bad
         $error("mfio_totalizer: parameters cannot be served");
      end
   endgenerate

   // bit 0 pulse input, bit 1 high gate, bit 2 low gate
   typedef struct packed {
      logic [2:0] sy1;   // first synchroniser stage
      logic [2:0] sy2;   // second synchroniser stage
      logic prev;        // delayed pulse for edge detect
      logic [CNT_W-1:0] cnt;
   } mfio_tot_st_t;

   mfio_tot_st_t st_r;
   mfio_tot_st_t st_nxt;
   logic rise;      // synchronised rising edge
   logic fall;      // synchronised falling edge
   logic gate_ok;   // both gates enabling
   logic inc;       // qualifying edge this cycle

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.sy1 = {gate_lo_n_i, gate_hi_i, cnt_in_i};
      st_nxt.sy2 = st_r.sy1;
      st_nxt.prev = st_r.sy2[0];
      // edges only from the second stage, never the first
      rise = st_r.sy2[0] & ~st_r.prev;
      fall = ~st_r.sy2[0] & st_r.prev;
      // high gate enables when high, low gate when low
      gate_ok = st_r.sy2[1] & ~st_r.sy2[2];
      inc = (edge_fall_i ? fall : rise) & gate_ok;
      if (clr_i) begin
         // software clear takes priority over a coincident edge
         st_nxt.cnt = '0;
      end else if (inc) begin
         // plain binary add wraps from all ones to zero
         st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign count_o = st_r.cnt;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   a_sync_two_stage: assert property (st_r.sy2[0] == $past(cnt_in_i, 2))
      else $error("pulse input not synchronised in two stages");
   a_gate_hi_blocks: assert property ((!st_r.sy2[1] && !clr_i) |=> st_r.cnt == $past(st_r.cnt))
      else $error("count moved with high gate low");
   a_gate_lo_blocks: assert property ((st_r.sy2[2] && !clr_i) |=> st_r.cnt == $past(st_r.cnt))
      else $error("count moved with low gate high");
   a_gated_increment: assert property ((inc && !clr_i && st_r.cnt != '1)
      |=> st_r.cnt == $past(st_r.cnt) + CNT_W'(1))
      else $error("qualified edge not counted once");
   a_wrong_edge: assert property ((edge_fall_i && rise && !clr_i) |=> st_r.cnt == $past(st_r.cnt))
      else $error("rising edge counted in falling mode");
   a_count_wrap: assert property ((inc && !clr_i && st_r.cnt == '1) |=> st_r.cnt == '0)
      else $error("count did not wrap to zero");

endmodule : mfio_totalizer

//--- sim/mfio_far_side.sv
`timescale 1ns/100ps
// ****************************************************************
// far side: pulse source, gates, port lines, sense
// ****************************************************************
module mfio_far_side (
   // clock
   input wire logic core_clk_i,
   // port pins
   input wire logic [15:0] pio_oe_i,
   output logic [15:0] pio_in_o,
   // totalizer pins
   output logic cnt_ttl_o,
   output logic cnt_ac_o,
   output logic gate_hi_o,
   output logic gate_lo_n_o,
   // sense readings
   output logic [35:0] sense_o
);
   logic [15:0] ext_r = 16'hffff;  // outside drivers, 0 sinks the line
   logic [35:0] sense_r = 36'h0;   // analog sense codes
   // pulled-up line: low when either party sinks it
   assign pio_in_o = ext_r & ~pio_oe_i;
   assign sense_o = sense_r;
   initial begin
      cnt_ttl_o = 1'b0;
      cnt_ac_o = 1'b0;
      gate_hi_o = 1'b0;
      gate_lo_n_o = 1'b1;
   end
   // four cycles high and five low per pulse, above the three cycle minimum
   task automatic pulses(input int n, input logic ac);
      for (int k = 0; k < n; k++) begin
         @(posedge core_clk_i);
         cnt_ac_o <= ac;
         cnt_ttl_o <= !ac;
         repeat (4) @(posedge core_clk_i);
         cnt_ac_o <= 1'b0;
         cnt_ttl_o <= 1'b0;
         repeat (4) @(posedge core_clk_i);
      end
   endtask : pulses
   task automatic gates(input logic hi, input logic lo_n);
      @(posedge core_clk_i);
      gate_hi_o <= hi;
      gate_lo_n_o <= lo_n;
   endtask : gates
endmodule : mfio_far_side

//--- sim/mfio_top_bench.sv
`timescale 1ns/100ps
module mfio_top_bench;
   import mfio_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   mfio_bus_req_t req = '0;
   logic scan_start = 1'b0;
   logic [31:0] rdata;
   logic [15:0] pin, oe, pout;
   logic ttl, ac, ghi, glo_n;
   logic [35:0] sense, dac;
   logic [1:0] cur;
   mfio_reading_t scan;
   logic rd_pend = 1'b0;
   logic [33:0] exp_q[$], scan_q[$];  // expected reads and readings
   int n_errors = 0;
   int num_checks = 0;
   int seed = 32'h742d551a;
   logic [17:0] d;
   logic [15:0] e;
   always #10 core_clk_i = ~core_clk_i;
   mfio_top uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus_req_i(req), .bus_rdata_o(rdata),
      .pio_in_i(pin), .pio_out_o(pout), .pio_oe_o(oe), .cnt_ttl_i(ttl), .cnt_ac_i(ac), .gate_hi_i(ghi),
      .gate_lo_n_i(glo_n), .dac_code_o(dac), .dac_cur_mode_o(cur), .sense_code_i(sense),
      .scan_start_i(scan_start), .scan_rd_o(scan));
   mfio_far_side far (.core_clk_i(core_clk_i), .pio_oe_i(oe), .pio_in_o(pin), .cnt_ttl_o(ttl),
      .cnt_ac_o(ac), .gate_hi_o(ghi), .gate_lo_n_o(glo_n), .sense_o(sense));
   // wide enough for mode bits beside both output codes
   task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one-cycle strobes, released at the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk_i);
      req <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0, remote: 1'b0};
      @(posedge core_clk_i);
      req.we <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic rem, input logic [31:0] v);
      exp_q.push_back({2'b0, v});
      @(posedge core_clk_i);
      req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1, remote: rem};
      @(posedge core_clk_i);
      req.re <= 1'b0;
   endtask : rd
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   // bounded wait until every noted result has been seen
   task automatic drain;
      for (int i = 0; i < 50 && (exp_q.size() + scan_q.size()) > 0; i++) @(posedge core_clk_i);
      chk("pending results", 40'(exp_q.size() + scan_q.size()), 40'h0);
   endtask : drain
   // ****************************************************************
   // monitor: read data one cycle after the strobe
   // ****************************************************************
   always @(posedge core_clk_i) rd_pend <= req.re;
   always @(negedge core_clk_i) begin
      if (rd_pend) chk("bus read", {2'b0, rdata}, exp_q.pop_front());
      if (scan.valid === 1'b1) chk("scan reading", {scan.chan, scan.data}, scan_q.pop_front());
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rd(OFS_CTRL, 1'b0, 32'h0);
      rd(OFS_COUNT, 1'b0, 32'h0);
      d = 18'($random(seed));
      far.sense_r <= {18'($random(seed)), d};
      wr(OFS_DAC0, {14'h0, d});
      wr(OFS_DAC1, {14'h0, ~d});
      wr(OFS_CTRL, 32'h20);
      // registered outputs only settle after the edge that took the write
      @(negedge core_clk_i);
      chk("dac codes", {cur, dac[35:18], ~dac[17:0]}, {2'b01, ~d, ~d});
      rd(OFS_DAC1, 1'b0, {14'h0, ~d});
      rd(OFS_SENSE0, 1'b0, {14'h0, d});
      $display("analog outputs done");
      e = 16'($random(seed));
      far.ext_r <= e;
      wr(OFS_PORT0, 32'h0f);
      @(negedge core_clk_i);
      chk("port drive", {pout, oe}, {16'h0, 16'h00f0});
      rd(OFS_PORT0, 1'b0, {24'h0, e[7:0] & 8'h0f});
      rd(OFS_PORT1, 1'b0, {24'h0, e[15:8]});
      rd(OFS_PORT16, 1'b1, {16'h0, e[15:8], e[7:0] & 8'h0f});
      rd(OFS_PORT16, 1'b0, 32'h0);
      rd(OFS_STATUS, 1'b0, 32'h1);
      wr(OFS_STATUS, 32'h1);
      rd(OFS_STATUS, 1'b0, 32'h0);
      $display("digital ports done");
      far.gates(1'b1, 1'b0);
      far.pulses(7, 1'b0);
      repeat (6) @(posedge core_clk_i);
      rd(OFS_COUNT, 1'b0, 32'd7);
      // both gates, then the low gate alone, then the high gate alone, block counting
      for (int g = 0; g < 3; g++) begin
         far.gates(g[0], !g[1]);
         far.pulses(3, 1'b0);
         rd(OFS_COUNT, 1'b0, 32'd7);
      end
      far.gates(1'b1, 1'b0);
      wr(OFS_CTRL, 32'h1);
      far.pulses(4, 1'b0);
      repeat (6) @(posedge core_clk_i);
      rd(OFS_COUNT, 1'b0, 32'd11);
      wr(OFS_CTRL, 32'h2);
      far.pulses(2, 1'b0);
      far.pulses(3, 1'b1);
      repeat (6) @(posedge core_clk_i);
      rd(OFS_COUNT, 1'b0, 32'd14);
      $display("totalizer done");
      wr(OFS_CTRL, 32'h1c);
      rd(OFS_PORT16, 1'b1, 32'h0);
      scan_q.push_back({CH_PORT0, 18'h0, e[7:0] & 8'h0f});
      scan_q.push_back({CH_PORT1, 18'h0, e[15:8]});
      scan_q.push_back({CH_COUNT, 26'd14});
      @(posedge core_clk_i);
      scan_start <= 1'b1;
      @(posedge core_clk_i);
      scan_start <= 1'b0;
      // the count reading must leave before the clear lands
      drain();
      wr(OFS_COUNT, 32'h0);
      rd(OFS_COUNT, 1'b0, 32'h0);
      far.pulses(2, 1'b0);
      repeat (6) @(posedge core_clk_i);
      rd(OFS_COUNT, 1'b0, 32'd2);
      // mid-run reset drops a live count and the settings
      rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rd(OFS_COUNT, 1'b0, 32'h0);
      rd(OFS_CTRL, 1'b0, 32'h0);
      drain();
      $display("scan done");
      report_and_stop();
   end
endmodule : mfio_top_bench
